// ### inc/plebc_pkg.sv
// constants for the pwm leading-edge blanking control block
package plebc_pkg;

   // apb register byte offsets
   localparam logic [11:0] PLEBC_OFS_EDGE_CTL   = 12'h000;
   localparam logic [11:0] PLEBC_OFS_DELAY      = 12'h004;
   localparam logic [11:0] PLEBC_OFS_AUX_CTL    = 12'h008;
   localparam logic [11:0] PLEBC_OFS_STATUS     = 12'h00C;

   // reset values
   localparam logic [15:0] PLEBC_RST_EDGE_CTL   = 16'h0000;
   localparam logic [8:0]  PLEBC_RST_DELAY      = 9'h000;
   localparam logic [3:0]  PLEBC_RST_SRC_SEL    = 4'h0;

   // writable bits per register
   localparam logic [15:0] PLEBC_MASK_EDGE_CTL  = 16'hFC3F;
   localparam logic [15:0] PLEBC_MASK_DELAY     = 16'h0FF8;
   localparam logic [15:0] PLEBC_MASK_AUX_CTL   = 16'h000F;

   // edge_blanking_control field positions
   localparam int PLEBC_B_HIGH_RISE  = 15;
   localparam int PLEBC_B_HIGH_FALL  = 14;
   localparam int PLEBC_B_LOW_RISE   = 13;
   localparam int PLEBC_B_LOW_FALL   = 12;
   localparam int PLEBC_B_FAULT_EN   = 11;
   localparam int PLEBC_B_CLIM_EN    = 10;
   localparam int PLEBC_B_SEL_HIGH   = 5;
   localparam int PLEBC_B_SEL_LOW    = 4;
   localparam int PLEBC_B_HOUT_HIGH  = 3;
   localparam int PLEBC_B_HOUT_LOW   = 2;
   localparam int PLEBC_B_LOUT_HIGH  = 1;
   localparam int PLEBC_B_LOUT_LOW   = 0;

   // delay register field: count lives in bits 11:3
   localparam int PLEBC_DLY_LSB      = 3;
   localparam int PLEBC_DLY_W        = 9;
   localparam int PLEBC_SEL_W        = 4;

   // timing, in units of 10 ps
   localparam int PLEBC_STEP_TIME_10PS = 832;   // 8.32 ns per delay count
   localparam int PLEBC_CLK_TIME_10PS  = 1000;  // 10 ns pclk period
   localparam int PLEBC_REM_W          = 19;    // holds 511 * 832

   // status field positions
   localparam int PLEBC_S_ACTIVE     = 19;
   localparam int PLEBC_S_STATE      = 20;
   localparam int PLEBC_S_FAULT_IN   = 21;
   localparam int PLEBC_S_CLIM_IN    = 22;

endpackage

// ### src/plebc_top.sv
// leading-edge and state blanking control for one pwm generator pair
//
// Overview of operation
// [RULE_01] low-side rising edge restarts blanking when enabled
// [RULE_02] low-side falling edge restarts blanking when enabled
// [RULE_03] fault input masked only when fault blanking enabled
// [RULE_04] current-limit masked only when its blanking enabled
// [RULE_05] blank while selected signal high, if enabled
// [RULE_06] blank while selected signal low, if enabled
// [RULE_07] nine-bit delay count, 8.32 ns per step
// [RULE_08] four-bit selector picks state blanking signal
// [RULE_09] counter loads on trigger, counts down, masks inputs
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module plebc_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        pwm_low_side_output,
   input  wire logic        pwm_high_side_output,
   input  wire logic        fault_in,
   input  wire logic        current_limit_in,
   input  wire logic [15:0] blank_src,
   output logic             fault_out,
   output logic             current_limit_out,
   output logic             blanking_active
);
   import plebc_pkg::*;

   // merge bytes under strobe, keeping only writable bits
   function automatic logic [15:0] strobe_merge(
      input logic [15:0] old_val,
      input logic [31:0] wdata,
      input logic [3:0]  strb,
      input logic [15:0] wmask
   );
      logic [15:0] lanes;
      lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
      strobe_merge = (old_val & ~lanes) | (wdata[15:0] & lanes);
   endfunction

   // software-visible state
   logic [15:0]                 edge_blanking_control;
   logic [15:0]                 delay_reg;
   logic [PLEBC_SEL_W-1:0]      blanking_source_select;

   // synchronised pins
   logic                        fault_meta;
   logic                        fault_sync;
   logic                        clim_meta;
   logic                        clim_sync;
   logic [15:0]                 src_meta;
   logic [15:0]                 src_sync;

   // edge detection and counting
   logic                        low_prev;
   logic                        high_prev;
   logic [PLEBC_REM_W-1:0]      remaining;
   logic [PLEBC_REM_W-1:0]      next_remaining;

   // field views
   wire                         low_out_rise_trigger_en;
   wire                         low_out_fall_trigger_en;
   wire                         high_out_rise_trigger_en;
   wire                         high_out_fall_trigger_en;
   wire                         fault_blanking_en;
   wire                         current_limit_blanking_en;
   wire                         blank_on_select_high;
   wire                         blank_on_select_low;
   wire [PLEBC_DLY_W-1:0]       blanking_delay_count;

   assign low_out_rise_trigger_en   = edge_blanking_control[PLEBC_B_LOW_RISE];
   assign low_out_fall_trigger_en   = edge_blanking_control[PLEBC_B_LOW_FALL];
   assign high_out_rise_trigger_en  = edge_blanking_control[PLEBC_B_HIGH_RISE];
   assign high_out_fall_trigger_en  = edge_blanking_control[PLEBC_B_HIGH_FALL];
   assign fault_blanking_en         = edge_blanking_control[PLEBC_B_FAULT_EN];
   assign current_limit_blanking_en = edge_blanking_control[PLEBC_B_CLIM_EN];
   assign blank_on_select_high      = edge_blanking_control[PLEBC_B_SEL_HIGH];
   assign blank_on_select_low       = edge_blanking_control[PLEBC_B_SEL_LOW];
   assign blanking_delay_count      = delay_reg[PLEBC_DLY_LSB +: PLEBC_DLY_W];

   // apb decode; slave never waits, so every access is one access cycle
   wire        acc         = psel & penable;
   wire        hit_edge    = (paddr == PLEBC_OFS_EDGE_CTL);
   wire        hit_delay   = (paddr == PLEBC_OFS_DELAY);
   wire        hit_aux     = (paddr == PLEBC_OFS_AUX_CTL);
   wire        hit_status  = (paddr == PLEBC_OFS_STATUS);
   wire        hit_any     = hit_edge | hit_delay | hit_aux | hit_status;
   wire        wr_edge     = acc & pwrite & hit_edge;
   wire        wr_delay    = acc & pwrite & hit_delay;
   wire        wr_aux      = acc & pwrite & hit_aux;

   assign pready  = 1'b1;
   // unmapped addresses and writes to status are flagged, data ignored
   assign pslverr = acc & (~hit_any | (pwrite & hit_status));

   // pwm outputs come from the same clock: edges seen directly
   wire low_rise  = pwm_low_side_output & ~low_prev;
   wire low_fall  = ~pwm_low_side_output & low_prev;
   wire high_rise = pwm_high_side_output & ~high_prev;
   wire high_fall = ~pwm_high_side_output & high_prev;

   // trigger select; any enabled edge restarts blanking
   // [RULE_01] low rise trigger
   wire trig_low_rise  = low_out_rise_trigger_en & low_rise;
   // [RULE_02] low fall trigger
   wire trig_low_fall  = low_out_fall_trigger_en & low_fall;
   wire trig_high      = (high_out_rise_trigger_en & high_rise)
                       | (high_out_fall_trigger_en & high_fall);
   wire trigger        = trig_low_rise | trig_low_fall | trig_high;

   // [RULE_07] step time in 10 ps units
   wire [PLEBC_REM_W-1:0] load_time =
      PLEBC_REM_W'(blanking_delay_count * PLEBC_STEP_TIME_10PS);
   wire [PLEBC_REM_W-1:0] clk_time  = PLEBC_REM_W'(PLEBC_CLK_TIME_10PS);

   // [RULE_09] reload on trigger, else count down; partial period rounds up
   always_comb begin
      if (trigger) begin
         next_remaining = load_time;
      end else if (remaining > clk_time) begin
         next_remaining = remaining - clk_time;
      end else begin
         next_remaining = '0;
      end
   end

   wire leb_active = (remaining != '0);

   // [RULE_08] selected state-blanking signal
   wire sel_signal = src_sync[blanking_source_select];

   // state blanking from selected signal and output levels
   // [RULE_05] blank while selected high
   wire blank_sel_hi = blank_on_select_high & sel_signal;
   // [RULE_06] blank while selected low
   wire blank_sel_lo = blank_on_select_low & ~sel_signal;
   wire blank_out    = (edge_blanking_control[PLEBC_B_HOUT_HIGH] & pwm_high_side_output)
                     | (edge_blanking_control[PLEBC_B_HOUT_LOW]  & ~pwm_high_side_output)
                     | (edge_blanking_control[PLEBC_B_LOUT_HIGH] & pwm_low_side_output)
                     | (edge_blanking_control[PLEBC_B_LOUT_LOW]  & ~pwm_low_side_output);
   wire state_blank  = blank_sel_hi | blank_sel_lo | blank_out;
   wire blank_now    = leb_active | state_blank;

   // masked inputs; a disabled mask lets the input straight through
   // [RULE_03] fault masking gate
   wire next_fault = fault_sync & ~(blank_now & fault_blanking_en);
   // [RULE_04] current-limit masking gate
   wire next_clim  = clim_sync & ~(blank_now & current_limit_blanking_en);

   // read mux
   wire [31:0] status_word = {9'h000,
                              clim_sync,
                              fault_sync,
                              state_blank,
                              leb_active,
                              remaining};
   wire [31:0] next_prdata =
      hit_edge   ? {16'h0000, edge_blanking_control} :
      hit_delay  ? {16'h0000, delay_reg} :
      hit_aux    ? {28'h000_0000, blanking_source_select} :
      hit_status ? status_word : 32'h0000_0000;

   // two-stage synchronisers for pins; first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_meta <= 1'b0;
         fault_sync <= 1'b0;
         clim_meta  <= 1'b0;
         clim_sync  <= 1'b0;
         src_meta   <= 16'h0000;
         src_sync   <= 16'h0000;
      end else begin
         fault_meta <= fault_in;
         fault_sync <= fault_meta;
         clim_meta  <= current_limit_in;
         clim_sync  <= clim_meta;
         src_meta   <= blank_src;
         src_sync   <= src_meta;
      end
   end

   // register writes, honouring byte strobes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_blanking_control  <= PLEBC_RST_EDGE_CTL;
         delay_reg              <= {4'h0, PLEBC_RST_DELAY, 3'h0};
         blanking_source_select <= PLEBC_RST_SRC_SEL;
      end else begin
         if (wr_edge) begin
            edge_blanking_control <= strobe_merge(edge_blanking_control, pwdata, pstrb,
                                                  PLEBC_MASK_EDGE_CTL);
         end
         if (wr_delay) begin
            delay_reg <= strobe_merge(delay_reg, pwdata, pstrb, PLEBC_MASK_DELAY);
         end
         if (wr_aux && pstrb[0]) begin
            blanking_source_select <= pwdata[PLEBC_SEL_W-1:0];
         end
      end
   end

   // read data is captured in the setup cycle so it is stable in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_prdata;
      end
   end

   // blanking counter and edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_prev  <= 1'b0;
         high_prev <= 1'b0;
         remaining <= '0;
      end else begin
         low_prev  <= pwm_low_side_output;
         high_prev <= pwm_high_side_output;
         remaining <= next_remaining;
      end
   end

   // registered masked outputs, one cycle after the synchronised input
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_out         <= 1'b0;
         current_limit_out <= 1'b0;
         blanking_active   <= 1'b0;
      end else begin
         fault_out         <= next_fault;
         current_limit_out <= next_clim;
         blanking_active   <= blank_now;
      end
   end

endmodule

`default_nettype wire

// ### tb/plebc_sva.sv
// assertion checker for the blanking control block
`timescale 1ns/10ps
`default_nettype none
module plebc_sva (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        pwm_low_side_output,
   input wire logic        fault_in,
   input wire logic        current_limit_in,
   input wire logic [15:0] blank_src,
   input wire logic        fault_out,
   input wire logic        current_limit_out,
   input wire logic        blanking_active
);
   logic [15:0] ctl;
   logic [8:0]  dly;
   logic [3:0]  sel;
   logic        low_q;
   logic [1:0]  up;
   logic [9:0]  run;
   // accepted write and enabled low-side edge, as the block should see them
   wire         wr   = psel & penable & pwrite & pready & !pslverr;
   wire         trig = (pwm_low_side_output ^ low_q) & (pwm_low_side_output ? ctl[13] : ctl[12]);
   wire  [9:0]  lim  = 10'((19'(dly) * 19'd832 + 19'd999) / 19'd1000);
   // shadow settings; run counts blanking cycles since the last trigger
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl   <= '0;
         dly   <= '0;
         sel   <= '0;
         low_q <= 1'b0;
         up    <= '0;
         run   <= '0;
      end else begin
         low_q <= pwm_low_side_output;
         if (up != 2'd3) up <= up + 2'd1;
         if (wr && paddr == 12'h000) ctl <= pwdata[15:0];
         if (wr && paddr == 12'h004) dly <= pwdata[11:3];
         if (wr && paddr == 12'h008) sel <= pwdata[3:0];
         if (trig) run <= '0;
         else if (blanking_active) run <= run + 10'd1;
         else run <= '0;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   rise_trig_a: assert property (trig && pwm_low_side_output && dly != 0 |-> ##2 blanking_active)
      else $error("no blanking after rising edge");
   fall_trig_a: assert property (trig && !pwm_low_side_output && dly != 0 |-> ##2 blanking_active)
      else $error("no blanking after falling edge");
   flt_mask_a: assert property (blanking_active && $past(ctl[11]) |-> !fault_out)
      else $error("fault passed while blanked");
   flt_pass_a: assert property (up == 2'd3 && !(blanking_active && $past(ctl[11])) |-> fault_out == $past(fault_in, 3))
      else $error("fault path wrong");
   clim_mask_a: assert property (blanking_active && $past(ctl[10]) |-> !current_limit_out)
      else $error("current limit passed while blanked");
   clim_pass_a: assert property (up == 2'd3 && !(blanking_active && $past(ctl[10])) |-> current_limit_out == $past(current_limit_in, 3))
      else $error("current limit path wrong");
   high_blk_a: assert property (up == 2'd3 && $past(ctl[5]) && $past(blank_src[sel], 3) |-> blanking_active)
      else $error("no blanking on high select");
   low_blk_a: assert property (up == 2'd3 && $past(ctl[4]) && !$past(blank_src[sel], 3) |-> blanking_active)
      else $error("no blanking on low select");
   dly_len_a: assert property (ctl[5:0] == '0 && $past(ctl[5:0], 3) == '0 |-> run <= lim + 10'd1)
      else $error("blanking longer than delay count");
   cover property (trig ##2 blanking_active);
   cover property (fault_in && blanking_active && !fault_out);
   cover property ($fell(blanking_active));
endmodule
bind plebc_top plebc_sva i_sva (.*);
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the blanking control block
`timescale 1ns/10ps
`default_nettype none
module tb;
   import plebc_pkg::*;
   localparam int WIN = 440;
   typedef struct {logic [15:0] ctl; logic [8:0] dly; logic [15:0] src; logic lvl; int n; int f; int c;} plebc_row_s;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic [3:0]  pstrb = 4'hF;
   logic        pready, pslverr, fault_out, current_limit_out, blanking_active, e;
   logic        pwm_low_side_output = 1'b0, pwm_high_side_output = 1'b0, fault_in = 1'b1, current_limit_in = 1'b1;
   logic [15:0] blank_src = '0;
   logic [15:0] msk [3] = '{16'hFC3F, 16'h0FF8, 16'h000F};
   int          num_errors = 0, cmp_count = 0, n, f, c;
   // ctl, delay, sources, new level, then blanking, fault and limit cycles
   plebc_row_s rows [14] = '{
      '{16'h2800, 9'h005, 16'h0000, 1'b1, 5, 5, 0}, '{16'h2400, 9'h005, 16'h0000, 1'b1, 5, 0, 5},
      '{16'h2000, 9'h005, 16'h0000, 1'b0, 0, 0, 0}, '{16'h1000, 9'h005, 16'h0000, 1'b0, 5, 0, 0},
      '{16'h1000, 9'h005, 16'h0000, 1'b1, 0, 0, 0}, '{16'h1C00, 9'h001, 16'h0000, 1'b0, 1, 1, 1},
      '{16'h3C00, 9'h1FF, 16'h0000, 1'b1, 426, 426, 426}, '{16'h3C00, 9'h000, 16'h0000, 1'b1, 0, 0, 0},
      '{16'h0820, 9'h000, 16'h0008, 1'b1, WIN, WIN, 0}, '{16'h0820, 9'h000, 16'h0000, 1'b1, 0, 0, 0},
      '{16'h0410, 9'h000, 16'h0000, 1'b1, WIN, 0, WIN}, '{16'h0410, 9'h000, 16'h0008, 1'b1, 0, 0, 0},
      '{16'h0802, 9'h000, 16'h0000, 1'b1, WIN-1, WIN-1, 0}, '{16'h0801, 9'h000, 16'h0000, 1'b1, 1, 1, 0}};
   plebc_top i_dut (.*);
   always #5 pclk = ~pclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // one apb transfer, held until pready, then one idle cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         num_errors++;
         report_and_stop();
      end
      @(posedge pclk);
   endtask
   // make the pwm edge and count masked cycles over a fixed window
   task automatic run(input logic lvl);
      n = 0;
      f = 0;
      c = 0;
      pwm_low_side_output <= lvl;
      repeat (WIN) begin
         @(posedge pclk);
         n += int'(blanking_active === 1'b1);
         f += int'(fault_out === 1'b0);
         c += int'(current_limit_out === 1'b0);
      end
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      chk({fault_out, current_limit_out, blanking_active, pready}, 32'h0000_0001);
      presetn <= 1'b1;
      @(posedge pclk);
      // reset values and writable bits of the settings registers
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 12'(4 * i), '0);
         chk(r, '0);
         apb(1'b1, 12'(4 * i), 32'hFFFF_FFFF);
         apb(1'b0, 12'(4 * i), '0);
         chk(r, {16'h0000, msk[i]});
         apb(1'b1, 12'(4 * i), '0);
      end
      apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
      chk(32'(e), 32'h0000_0001);
      apb(1'b0, 12'h010, '0);
      chk(32'(e), 32'h0000_0001);
      chk(r, '0);
      $display("register test done");
      // selector picks source line 3
      apb(1'b1, 12'h008, 32'h0000_0003);
      foreach (rows[i]) begin
         apb(1'b1, 12'h000, '0);
         pwm_low_side_output <= ~rows[i].lvl;
         apb(1'b1, 12'h004, {20'h0_0000, rows[i].dly, 3'h0});
         apb(1'b1, 12'h000, {16'h0000, rows[i].ctl});
         blank_src <= rows[i].src;
         repeat (4) @(posedge pclk);
         run(rows[i].lvl);
         chk(n, rows[i].n);
         chk(f, rows[i].f);
         chk(c, rows[i].c);
         $display("row %0d done", i);
      end
      // high-side rising edge as the only enabled trigger
      apb(1'b1, 12'h000, '0);
      apb(1'b1, 12'h004, 32'h0000_0028);
      apb(1'b1, 12'h000, 32'h0000_8800);
      pwm_high_side_output <= 1'b1;
      n = 0;
      f = 0;
      repeat (WIN) begin
         @(posedge pclk);
         n += int'(blanking_active === 1'b1);
         f += int'(fault_out === 1'b0);
      end
      chk(n, 5);
      chk(f, 5);
      $display("high-side trigger test done");
      // reset in mid-run clears outputs and settings
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({fault_out, current_limit_out, blanking_active, pready}, 32'h0000_0001);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h000, '0);
      chk(r, '0);
      $display("mid-run reset test done");
      report_and_stop();
   end
endmodule
`default_nettype wire
